// ===== rts_pkg.sv
// Constants and types shared by the reset time-out sequencer
// Assumes a single 200 MHz system clock
package rts_pkg;

  // ==========================================================
  // Timing
  localparam int CNT_W = 19;
  localparam logic [CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = 19'h0_07FF;
  localparam logic [CNT_W-1:0] OST_LAST  = 19'h0_03FF;
  localparam logic [CNT_W-1:0] CNT_ONE   = 19'h0_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 19'h0_0000;
  localparam int PLL_LOCK_MS = 2;
  localparam int SYS_CLK_KHZ = 200_000;
  localparam int PLL_LOCK_CYC = PLL_LOCK_MS * SYS_CLK_KHZ;

  // ==========================================================
  // Program counter values
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
  localparam logic [PC_W-1:0] PC_STEP  = 21'h00_0002;
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h00_0008;
  localparam logic [PC_W-1:0] VEC_LOW  = 21'h00_0018;

  // ==========================================================
  // Brown-out configuration codes
  localparam logic [1:0] BOR_CFG_SOFT    = 2'h1;
  localparam logic [1:0] BOR_CFG_NOSLEEP = 2'h2;
  localparam logic [1:0] BOR_CFG_ALWAYS  = 2'h3;

  // ==========================================================
  // Synchronised input positions
  localparam int SYNC_N  = 5;
  localparam int SI_MASTER_CLEAR_PIN = 0;
  localparam int SI_RC   = 1;
  localparam int SI_OSC  = 2;
  localparam int SI_POR  = 3;
  localparam int SI_BOR  = 4;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    crystal_mode, fast_crystal_mode, fast_crystal_multiplied_mode,
    crystal_multiplied_mode, external_clock_mode, external_clock_io_mode,
    external_clock_multiplied_mode, internal_osc_io_mode,
    internal_osc_fast_crystal_mode, resistor_cap_osc_mode
  } rts_osc_mode_t;

  typedef enum logic [1:0] {PM_FULL, PM_RUN, PM_IDLE, PM_SLEEP} rts_pm_t;

  typedef enum logic [1:0] {CLS_POWER, CLS_WARM, CLS_WAKE} rts_class_t;

  typedef enum logic [2:0] {
    S_HOLD, S_POWERUP_DELAY_TIMER, S_OST, S_PLL, S_PIN, S_RUN
  } rts_state_t;

endpackage

// ===== rts_sync_if.sv
// Interface between the sequencer and its input synchroniser
// Assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface rts_sync_if;
  import rts_pkg::*;
  logic [SYNC_N-1:0] raw;
  logic [SYNC_N-1:0] lvl;
  logic [SYNC_N-1:0] rise;

  modport sync (input raw, output lvl, output rise);
  modport user (output raw, input lvl, input rise);
endinterface
`default_nettype wire

// ===== rts_in_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse
// Assumes raw inputs are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module rts_in_sync
  import rts_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Synchronised signals
  rts_sync_if.sync  sif
);

  // ==========================================================
  // Per-bit synchroniser
  genvar i;
  generate
    for (i = 0; i < SYNC_N; i++)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      // Filtered level moves only when stages two and three agree
      wire agree = (s2_q == s3_q);
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end
        else
        begin
          s1_q  <= sif.raw[i];
          s2_q  <= s1_q;
          s3_q  <= s2_q;
          lvl_q <= agree ? s3_q : lvl_q;
        end
      end
      assign sif.lvl[i]  = lvl_q;
      assign sif.rise[i] = agree & s3_q & ~lvl_q;
    end
  endgenerate

endmodule // rts_in_sync
`default_nettype wire

// ===== rts_sequencer.sv
// Reset time-out sequencer: timer chain, reset status flags, restart PC
// Assumes oscillator, RC clock, pin and analog detectors are asynchronous
//
// Notes on behaviour
// - Oscillator settle count is 1024 oscillator edges after power-up delay.
// - Settle count only in crystal modes, on power-on or sleep exit.
// - Crystal PLL modes add a 2 ms lock delay after the settle count.
// - After power-on clears: power-up delay if enabled, then settle count.
// - RC oscillator with power-up delay disabled: no time-out at all.
// - Timers run from power-on; pin high after expiry releases at once.
// - Power-up delay applies only when its disable bit is zero.
// - External clock and internal I/O modes: power-up delay only, PLL variant adds lock.
// - PLL lock delay sized 2 ms, on power-up and sleep exit.
// - Reset class output tells core which registers take reset values.
// - Watchdog wake-up is a resume, not a reset.
// - Power-on: PC zero, set enable and three flags, clear four flags.
// - Reset instruction clears its flag; brown-out sets three, clears its own.
// - Pin reset sets watchdog flag outside Full mode; also clears sleep flag asleep.
// - Watchdog: clear flag, restart zero; asleep also clear sleep, PC+2.
// - Stack errors with enable reset and flag; underflow without enable flags.
// - Interrupt wake clears sleep flag, PC+2 or vector when enabled.
// - Soft brown-out enable resets to 1 on power-on only in mode 01.
// - Power-up delay is 11-bit count of 2048 RC clock edges.
// - Power-on flag cleared by power-on, set only by software.
// - Soft brown-out enable reads zero outside mode 01.
`timescale 1ns/1ps
`default_nettype none
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
)
(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  // Asynchronous sources
  input  wire logic            master_clear_pin,
  input  wire logic            internal_rc_clock,
  input  wire logic            osc_clk_in,
  input  wire logic            por_active,
  input  wire logic            brownout_active,
  // Configuration
  input  wire rts_osc_mode_t   osc_mode,
  input  wire logic            powerup_delay_disable_n,
  input  wire logic [1:0]      brownout_config_bits,
  input  wire logic            stack_overflow_reset_enable,
  // Core events and state
  input  wire rts_pm_t         power_mode,
  input  wire logic            wdt_timeout,
  input  wire logic            reset_instr,
  input  wire logic            stack_overflow,
  input  wire logic            stack_underflow,
  input  wire logic            irq_wake,
  input  wire logic            irq_high_priority,
  input  wire logic            global_irq_enable_high,
  input  wire logic            global_irq_enable_low,
  input  wire logic [PC_W-1:0] pc_current,
  // Software writes
  input  wire logic            sw_por_flag_set,
  input  wire logic            sw_bor_flag_set,
  input  wire logic            sw_stack_flags_clr,
  input  wire logic            sw_sben_we,
  input  wire logic            sw_sben_data,
  // Reset and restart
  output var  logic            internal_reset,
  output var  logic            wake_stall,
  output var  logic [PC_W-1:0] restart_pc,
  output var  logic            restart_pc_load,
  output var  rts_class_t      reset_class,
  // Status flags
  output var  logic            soft_brownout_enable,
  output var  logic            reset_instr_flag_n,
  output var  logic            watchdog_expiry_flag_n,
  output var  logic            sleep_entry_flag_n,
  output var  logic            power_on_flag_n,
  output var  logic            brownout_flag_n,
  output var  logic            stack_full_flag,
  output var  logic            stack_underflow_flag
);
  localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_LOCK_CYCLES - 1);

  // ==========================================================
  // Input synchronisation
  rts_sync_if sif ();
  assign sif.raw = {brownout_active, por_active, osc_clk_in,
                    internal_rc_clock, master_clear_pin};

  rts_in_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sif     (sif)
  );

  wire master_clear_pin_hi  = sif.lvl[SI_MASTER_CLEAR_PIN];
  wire rc_rise  = sif.rise[SI_RC];
  wire osc_rise = sif.rise[SI_OSC];

  // ==========================================================
  // State
  rts_state_t      state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic            wake_q, rst_q, load_q;
  logic            ri_q, to_q, pd_q, por_q, bor_q, ful_q, unf_q, sben_q;
  logic [PC_W-1:0] pc_q;
  rts_class_t      cls_q;

  // ==========================================================
  // Mode decode
  wire sbor_cfg = (brownout_config_bits == BOR_CFG_SOFT);
  wire ost_need = osc_mode inside {crystal_mode, fast_crystal_mode,
                  fast_crystal_multiplied_mode, crystal_multiplied_mode,
                  internal_osc_fast_crystal_mode};
  wire pll_need = osc_mode inside {fast_crystal_multiplied_mode,
                  crystal_multiplied_mode,
                  external_clock_multiplied_mode};
  wire asleep   = (power_mode == PM_IDLE) || (power_mode == PM_SLEEP);
  wire in_run   = (state_q == S_RUN);

  // Brown-out detector only counts when its configuration enables it
  wire bor_en = (brownout_config_bits == BOR_CFG_ALWAYS)
             || (brownout_config_bits == BOR_CFG_NOSLEEP
                 && power_mode != PM_SLEEP)
             || (sbor_cfg && sben_q);
  wire por_s  = sif.lvl[SI_POR];
  wire bor_s  = sif.lvl[SI_BOR] && bor_en && !por_s;
  wire hard   = por_s || sif.lvl[SI_BOR] && bor_en;

  // ==========================================================
  // Event priority while running
  wire q_base   = in_run && !hard;
  wire t_master_clear_pin   = q_base && !master_clear_pin_hi;
  wire q_wdt    = q_base && master_clear_pin_hi;
  wire t_wdt    = q_wdt && wdt_timeout;
  wire q_stk    = q_wdt && !wdt_timeout;
  wire stk_ev   = stack_overflow || stack_underflow;
  wire t_stk    = q_stk && stk_ev && stack_overflow_reset_enable;
  wire suf_err  = q_stk && stack_underflow
               && !stack_overflow_reset_enable;
  wire q_ins    = q_stk && !t_stk;
  wire t_ins    = q_ins && reset_instr;
  wire t_irq    = q_ins && !reset_instr && irq_wake && asleep;
  wire wdt_wake = t_wdt && asleep;
  wire warm     = t_master_clear_pin || t_stk || t_ins || (t_wdt && !asleep);
  wire wake_go  = wdt_wake || t_irq;

  // ==========================================================
  // Stage sequencing
  wire powerup_delay_timer_on = !powerup_delay_disable_n;
  rts_state_t after_ost, after_powerup_delay_timer, first_stage;
  assign after_ost   = pll_need ? S_PLL : S_PIN;
  assign after_powerup_delay_timer  = ost_need ? S_OST : after_ost;
  assign first_stage = powerup_delay_timer_on ? S_POWERUP_DELAY_TIMER : after_powerup_delay_timer;

  wire powerup_delay_timer_done = rc_rise && (cnt_q == POWERUP_DELAY_TIMER_LAST);
  wire ost_done  = osc_rise && (cnt_q == OST_LAST);
  wire pll_done  = (cnt_q == PLL_LAST);
  always_comb
  begin
    state_d = state_q;
    if (hard)
      state_d = S_HOLD;
    else
    begin
      unique case (state_q)
        S_HOLD: state_d = first_stage;
        S_POWERUP_DELAY_TIMER: state_d = powerup_delay_timer_done ? after_powerup_delay_timer : S_POWERUP_DELAY_TIMER;
        S_OST:  state_d = ost_done ? after_ost : S_OST;
        S_PLL:  state_d = pll_done ? S_PIN : S_PLL;
        S_PIN:  state_d = master_clear_pin_hi ? S_RUN : S_PIN;
        S_RUN:
        begin
          if (warm)
            state_d = S_PIN;
          else if (wake_go)
            state_d = after_powerup_delay_timer;
        end
      endcase
    end
  end

  // Counter restarts on each stage change, so one counter serves all
  wire [CNT_W-1:0] cnt_inc = (state_q == S_POWERUP_DELAY_TIMER) ? CNT_W'(rc_rise)
                           : (state_q == S_OST)  ? CNT_W'(osc_rise)
                           : (state_q == S_PLL)  ? CNT_ONE : CNT_ZERO;
  assign cnt_d = (hard || state_d != state_q) ? CNT_ZERO
               : cnt_q + cnt_inc;
  wire wake_d  = (hard || warm) ? 1'b0 : wake_go ? 1'b1 : wake_q;
  wire rst_d   = (state_d != S_RUN) && !wake_d;
  wire load_d  = (state_d == S_RUN) && (state_q != S_RUN);

  // ==========================================================
  // Status flags, hardware events take priority over software
  wire ri_d  = hard ? 1'b1 : t_ins ? 1'b0 : ri_q;
  wire to_d  = hard ? 1'b1
             : (t_master_clear_pin && power_mode != PM_FULL) ? 1'b1
             : t_wdt ? 1'b0 : to_q;
  wire pd_d  = hard ? 1'b1
             : ((t_master_clear_pin || t_wdt) && asleep) || t_irq ? 1'b0
             : pd_q;
  wire por_d = por_s ? 1'b0 : sw_por_flag_set ? 1'b1 : por_q;
  wire bor_d = hard ? 1'b0 : sw_bor_flag_set ? 1'b1 : bor_q;
  wire ful_d = por_s ? 1'b0
             : (t_stk && stack_overflow) ? 1'b1
             : sw_stack_flags_clr ? 1'b0 : ful_q;
  wire unf_d = por_s ? 1'b0
             : (t_stk && stack_underflow) || suf_err ? 1'b1
             : sw_stack_flags_clr ? 1'b0 : unf_q;
  wire sben_d = por_s ? sbor_cfg
              : (bor_s || warm) ? (sben_q && sbor_cfg)
              : sw_sben_we ? sw_sben_data : sben_q;

  // ==========================================================
  // Restart address and reset class
  wire             gie    = global_irq_enable_high || global_irq_enable_low;
  wire [PC_W-1:0]  pc_nxt = pc_current + PC_STEP;
  wire [PC_W-1:0]  vec    = irq_high_priority ? VEC_HIGH : VEC_LOW;
  wire [PC_W-1:0]  pc_d   = (hard || warm) ? PC_RESET
                          : wdt_wake ? pc_nxt
                          : t_irq ? (gie ? vec : pc_nxt)
                          : pc_q;
  rts_class_t cls_d;
  assign cls_d = hard ? CLS_POWER : warm ? CLS_WARM
               : wake_go ? CLS_WAKE : cls_q;

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= S_HOLD;
      cnt_q   <= CNT_ZERO;
      wake_q  <= 1'b0;
      rst_q   <= 1'b1;
      load_q  <= 1'b0;
      pc_q    <= PC_RESET;
      cls_q   <= CLS_POWER;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      wake_q  <= wake_d;
      rst_q   <= rst_d;
      load_q  <= load_d;
      pc_q    <= pc_d;
      cls_q   <= cls_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {ri_q, to_q, pd_q} <= 3'h7;
      {por_q, bor_q, ful_q, unf_q} <= 4'h0;
      sben_q <= 1'b1;
    end
    else
    begin
      {ri_q, to_q, pd_q} <= {ri_d, to_d, pd_d};
      {por_q, bor_q, ful_q, unf_q} <= {por_d, bor_d, ful_d, unf_d};
      sben_q <= sben_d;
    end
  end

  // ==========================================================
  // Outputs
  assign internal_reset         = rst_q;
  assign wake_stall             = wake_q && !in_run;
  assign restart_pc             = pc_q;
  assign restart_pc_load        = load_q;
  assign reset_class            = cls_q;
  assign soft_brownout_enable   = sben_q && sbor_cfg;
  assign reset_instr_flag_n     = ri_q;
  assign watchdog_expiry_flag_n = to_q;
  assign sleep_entry_flag_n     = pd_q;
  assign power_on_flag_n        = por_q;
  assign brownout_flag_n        = bor_q;
  assign stack_full_flag        = ful_q;
  assign stack_underflow_flag   = unf_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ost_leave;
    state_q == S_OST && !hard ##1 state_q != S_OST;
  endsequence
  sequence s_pin_release;
    state_q == S_PIN && !wake_q && !hard ##1 state_q == S_RUN;
  endsequence
  chk_powerup_delay_timer_length: assert property (state_q == S_POWERUP_DELAY_TIMER && !hard
    && powerup_delay_timer_done |=> state_q != S_POWERUP_DELAY_TIMER)
    else $error("power-up delay end missed");
  chk_ost_count: assert property (s_ost_leave
    |-> $past(cnt_q) == OST_LAST)
    else $error("settle count left early");
  chk_ost_modes: assert property (state_q == S_OST |-> ost_need)
    else $error("settle count in wrong mode");
  chk_pll_lock_end: assert property (state_q == S_PLL && !hard
    && cnt_q == PLL_LAST |=> state_q == S_PIN)
    else $error("lock delay end missed");
  chk_pll_modes: assert property ($rose(state_q == S_PLL)
    |-> $past(pll_need))
    else $error("lock delay in non-PLL mode");
  chk_rc_no_delay: assert property (state_q == S_HOLD && !hard
    && osc_mode == resistor_cap_osc_mode && powerup_delay_disable_n
    |=> state_q == S_PIN)
    else $error("RC mode delayed");
  chk_powerup_delay_timer_enable: assert property (state_q == S_HOLD && !hard
    |=> (state_q == S_POWERUP_DELAY_TIMER) == $past(powerup_delay_timer_on))
    else $error("power-up delay enable wrong");
  chk_pin_release: assert property (s_pin_release
    |-> !internal_reset && $past(master_clear_pin_hi))
    else $error("release without pin high");
  chk_restart_chain: assert property (hard && state_q != S_HOLD
    |=> state_q == S_HOLD && cnt_q == CNT_ZERO ##1 state_q != S_RUN)
    else $error("chain not restarted");
  chk_por_flags: assert property (por_s |=> !power_on_flag_n
    && !brownout_flag_n && !stack_full_flag && reset_instr_flag_n
    && restart_pc == PC_RESET)
    else $error("power-on flags wrong");
  chk_instr_flag: assert property (t_ins |=> !reset_instr_flag_n
    && internal_reset && reset_class == CLS_WARM)
    else $error("reset instruction flag wrong");
  chk_wdt_sleep: assert property (wdt_wake |=> !watchdog_expiry_flag_n
    && !sleep_entry_flag_n && restart_pc == $past(pc_nxt)
    && !internal_reset)
    else $error("watchdog wake wrong");
  chk_stack_error: assert property (suf_err |=> stack_underflow_flag
    && state_q == S_RUN)
    else $error("underflow error handling wrong");

endmodule // rts_sequencer
`default_nettype wire

// ===== rts_far_model.sv
// Far-side model: the RC clock and the oscillator that the sequencer counts
// Assumes the sequencer samples both against a 200 MHz sys_clk
`timescale 1ns/1ps
`default_nettype none
module rts_far_model
#(
  parameter real RC_HALF_NS  = 20.0,
  parameter real OSC_HALF_NS = 15.0
)
(
  // Counted clocks
  output var logic internal_rc_clock,
  output var logic osc_clk_in
);
  // ==========================================================
  // Clock sources
  // Each half spans at least 3 sys_clk cycles, so no edge is lost in sync
  initial internal_rc_clock = 1'b0;
  initial osc_clk_in = 1'b0;
  always #(RC_HALF_NS) internal_rc_clock = ~internal_rc_clock;
  always #(OSC_HALF_NS) osc_clk_in = ~osc_clk_in;
endmodule // rts_far_model
`default_nettype wire

// ===== rts_sequencer_tb.sv
// Self-checking bench for the reset time-out sequencer
// Assumes rts_far_model supplies the counted clocks; lock delay cut to 20
`timescale 1ns/1ps
`default_nettype none
module rts_sequencer_tb;
  import rts_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic sys_clk = 0, rst_n = 0, pin = 1, por = 1, bo = 0, dis_n = 0;
  logic sore = 0, wdt = 0, rst_instr = 0, ovf = 0, unf = 0, irq = 0;
  logic hp = 0, gh = 0, gl = 0, swp = 0, swb = 0, swc = 0, swe = 0;
  logic [1:0] cfg = 2'h1;
  rts_osc_mode_t mode = fast_crystal_multiplied_mode;
  rts_pm_t pm = PM_FULL;
  logic [PC_W-1:0] pc = '0, m_pc, rpc;
  wire ireset, stall, ld, sbe, slow_clk, osc;
  wire o_rif, o_wdf, o_slf, o_pof, o_bof, o_sf, o_su;
  rts_class_t cls, m_cls;
  logic m_rif, m_wdf, m_slf, m_pof, m_bof, m_sf, m_su;
  logic [31:0] seed = 32'ha496_da4d;
  int fails = 0, total_checks = 0, n;
  int ev_c[11] = '{0, 1, 2, 3, 5, 5, 5, 4, 4, 4, 1};
  rts_pm_t ev_p[11] = '{PM_FULL, PM_FULL, PM_FULL, PM_FULL, PM_FULL,
    PM_RUN, PM_SLEEP, PM_IDLE, PM_IDLE, PM_SLEEP, PM_SLEEP};
  logic [2:0] ev_g[11] = '{0, 0, 0, 0, 0, 0, 0, 3'b101, 3'b010, 0, 0};

  always #2.5 sys_clk = ~sys_clk;

  rts_far_model rts_far_model_i (.internal_rc_clock(slow_clk),
    .osc_clk_in(osc));
  rts_sequencer #(.PLL_LOCK_CYCLES(20)) rts_sequencer_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .master_clear_pin(pin),
    .internal_rc_clock(slow_clk), .osc_clk_in(osc), .por_active(por),
    .brownout_active(bo), .osc_mode(mode), .powerup_delay_disable_n(dis_n),
    .brownout_config_bits(cfg), .stack_overflow_reset_enable(sore),
    .power_mode(pm), .wdt_timeout(wdt), .reset_instr(rst_instr),
    .stack_overflow(ovf), .stack_underflow(unf), .irq_wake(irq),
    .irq_high_priority(hp), .global_irq_enable_high(gh),
    .global_irq_enable_low(gl), .pc_current(pc), .sw_por_flag_set(swp),
    .sw_bor_flag_set(swb), .sw_stack_flags_clr(swc), .sw_sben_we(swe),
    .sw_sben_data(1'b0), .internal_reset(ireset), .wake_stall(stall),
    .restart_pc(rpc), .restart_pc_load(ld), .reset_class(cls),
    .soft_brownout_enable(sbe), .reset_instr_flag_n(o_rif),
    .watchdog_expiry_flag_n(o_wdf), .sleep_entry_flag_n(o_slf),
    .power_on_flag_n(o_pof), .brownout_flag_n(o_bof),
    .stack_full_flag(o_sf), .stack_underflow_flag(o_su));

  // ==========================================================
  // Helpers
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait until the core runs again, wake sequences included
  task automatic wait_run(output int k);
    k = 0;
    while ((ireset | stall) !== 1'b0 && k < 40000)
    begin
      step(1);
      k++;
    end
    check(k < 40000, 1);
  endtask

  task automatic check_flags();
    logic [6:0] seen_f, exp_f;
    seen_f = {o_rif, o_wdf, o_slf, o_pof, o_bof, o_sf, o_su};
    exp_f = {m_rif, m_wdf, m_slf, m_pof, m_bof, m_sf, m_su};
    check(seen_f, exp_f);
    check(rpc, m_pc);
  endtask

  // Power-on; with pin_lo > 0 the pin stays low that long, count from pin
  task automatic power_on(input rts_osc_mode_t md, input logic dn,
                          input int pin_lo, output int k);
    mode = md;
    dis_n = dn;
    por = 1'b1;
    rst_n = 1'b0;
    pin = (pin_lo == 0);
    step(10);
    rst_n = 1'b1;
    step(6);
    {m_rif, m_wdf, m_slf, m_pof, m_bof, m_sf, m_su} = 7'b111_0000;
    m_pc = PC_RESET;
    m_cls = CLS_POWER;
    por = 1'b0;
    if (pin_lo > 0)
    begin
      step(pin_lo);
      check(ireset, 1'b1);
      pin = 1'b1;
    end
    wait_run(k);
    check(ld, 1'b1);
    check(cls, m_cls);
  endtask

  // Codes: 0 reset instr, 1 watchdog, 2 overflow, 3 underflow, 4 irq, 5 pin
  task automatic event_run(input int c, input rts_pm_t p,
                           input logic [2:0] g);
    logic wake;
    int k;
    wake = (p == PM_IDLE || p == PM_SLEEP);
    pm = p;
    {gh, gl, hp} = g;
    sore = (c == 2);
    seed = lfsr_next(seed);
    pc = seed[PC_W-1:0];
    step(2);
    case (c)
      0: rst_instr = 1'b1;
      1: wdt = 1'b1;
      2: ovf = 1'b1;
      3: unf = 1'b1;
      4: irq = 1'b1;
      default: pin = 1'b0;
    endcase
    if (c == 0) m_rif = 1'b0;
    if (c == 1) m_wdf = 1'b0;
    if (c == 5 && p != PM_FULL) m_wdf = 1'b1;
    if ((c == 1 || c == 5) && wake || c == 4) m_slf = 1'b0;
    if (c == 2) m_sf = 1'b1;
    if (c == 3) m_su = 1'b1;
    if (c == 4) m_pc = (gh | gl) ? (hp ? VEC_HIGH : VEC_LOW) : pc + PC_STEP;
    else if (c == 1 && wake) m_pc = pc + PC_STEP;
    else if (c != 3) m_pc = PC_RESET;
    if (c != 3) m_cls = (c == 4 || c == 1 && wake) ? CLS_WAKE : CLS_WARM;
    step(1);
    {rst_instr, wdt, ovf, unf, irq} = 5'h0_0;
    if (c == 3) check(ireset, 1'b0);
    if (c == 5) step(8);
    pin = 1'b1;
    step(3);
    wait_run(k);
    step(2);
    check_flags();
    check(cls, m_cls);
    pm = PM_FULL;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    power_on(fast_crystal_multiplied_mode, 1'b0, 0, n);
    check(n >= 22530 && n <= 22600, 1);
    check_flags();
    check(sbe, 1'b1);
    foreach (ev_c[i]) event_run(ev_c[i], ev_p[i], ev_g[i]);
    // Software clears the stack flags and the soft brown-out enable
    {swc, swe} = 2'b11;
    step(1);
    {swc, swe} = 2'b00;
    {m_sf, m_su} = 2'b00;
    check(sbe, 1'b0);
    check_flags();
    // Brown-out after software set the power-on flag, no timers left
    mode = resistor_cap_osc_mode;
    dis_n = 1'b1;
    cfg = BOR_CFG_ALWAYS;
    {swp, swb} = 2'b11;
    step(1);
    {swp, swb} = 2'b00;
    check(sbe, 1'b0);
    check({o_pof, o_bof}, 2'b11);
    bo = 1'b1;
    step(8);
    bo = 1'b0;
    {m_rif, m_wdf, m_slf, m_pof, m_bof, m_pc} = {5'b1_1110, PC_RESET};
    step(3);
    wait_run(n);
    check_flags();
    check(cls, CLS_POWER);
    power_on(resistor_cap_osc_mode, 1'b1, 0, n);
    check(n <= 8, 1);
    power_on(external_clock_mode, 1'b1, 0, n);
    check(n <= 8, 1);
    power_on(external_clock_multiplied_mode, 1'b1, 0, n);
    check(n >= 18 && n <= 32, 1);
    power_on(crystal_mode, 1'b1, 7000, n);
    check(n <= 8, 1);
    check_flags();
    tally_and_finish();
  end

  // Whole plan takes about 56k cycles; 90k cycles means a hang
  initial
  begin
    #450_000;
    fails++;
    tally_and_finish();
  end
endmodule // rts_sequencer_tb
`default_nettype wire
